// ==== core/scmgo_pkg.sv ====
`default_nettype none

package scmgo_pkg;

	// ****************************************************************
	// Register addresses (3-bit serial address field)
	// ****************************************************************
	localparam logic [2:0] ADDR_CONFIG       = 3'h0;
	localparam logic [2:0] ADDR_ORDER        = 3'h1;
	localparam logic [2:0] ADDR_RED_GAIN     = 3'h2;
	localparam logic [2:0] ADDR_GREEN_GAIN   = 3'h3;
	localparam logic [2:0] ADDR_BLUE_GAIN    = 3'h4;
	localparam logic [2:0] ADDR_RED_OFFSET   = 3'h5;
	localparam logic [2:0] ADDR_GREEN_OFFSET = 3'h6;
	localparam logic [2:0] ADDR_BLUE_OFFSET  = 3'h7;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CFG_CHANNEL_COUNT_BIT = 5;
	localparam int CFG_DOUBLE_SAMPLE_BIT = 4;
	localparam int ORD_COLOUR_ORDER_BIT  = 7;
	localparam int ORD_RED_BIT           = 6;
	localparam int ORD_GREEN_BIT         = 5;
	localparam int ORD_BLUE_BIT          = 4;
	localparam int OFS_SIGN_BIT          = 8;

	// Writable bits; the rest are kept at zero
	localparam logic [8:0] CONFIG_MASK = 9'h0fc;
	localparam logic [8:0] ORDER_MASK  = 9'h0f0;
	localparam logic [8:0] GAIN_MASK   = 9'h03f;
	localparam logic [8:0] OFFSET_MASK = 9'h1ff;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [8:0] CONFIG_RESET = 9'h078;
	localparam logic [8:0] ORDER_RESET  = 9'h0c0;
	localparam logic [8:0] GAIN_RESET   = 9'h000;
	localparam logic [8:0] OFFSET_RESET = 9'h000;

	// ****************************************************************
	// Gain law: 5.7 / (1 + 4.7*(63-G)/63), scaled by 1000
	// ****************************************************************
	localparam int GAIN_MAX_CODE   = 63;
	localparam int GAIN_TOP_MILLI  = 5700;
	localparam int GAIN_SLOPE_MILL = 4700;
	localparam int GAIN_UNIT_MILLI = 1000;

	// Offset step in microvolts: 350 mV over 255 magnitude codes
	localparam int OFFSET_SPAN_UV = 350000;
	localparam int OFFSET_MAG_MAX = 255;

	// Multiplexer channel codes
	typedef enum logic [1:0] {
		CH_RED,
		CH_GREEN,
		CH_BLUE
	} scmgo_chan_t;

endpackage

`default_nettype wire

// ==== core/scmgo_regfile.sv ====
`timescale 1ns/1ps
`default_nettype none

// Eight nine-bit registers, registered read port
module scmgo_regfile (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Write port
	input  wire logic       wr_en,
	input  wire logic [2:0] wr_addr,
	input  wire logic [8:0] wr_data,
	// Read port
	input  wire logic [2:0] rd_addr,
	output logic      [8:0] rd_data,
	// Full image for the datapath
	output logic      [71:0] image
);

	logic [8:0] mem_reg [8];
	logic [8:0] rd_data_reg;

	function automatic logic [8:0] reset_of(input int idx);
		if (idx == 0) begin
			reset_of = scmgo_pkg::CONFIG_RESET;
		end else if (idx == 1) begin
			reset_of = scmgo_pkg::ORDER_RESET;
		end else if (idx < 5) begin
			reset_of = scmgo_pkg::GAIN_RESET;
		end else begin
			reset_of = scmgo_pkg::OFFSET_RESET;
		end
	endfunction

	function automatic logic [8:0] mask_of(input logic [2:0] a);
		if (a == scmgo_pkg::ADDR_CONFIG) begin
			mask_of = scmgo_pkg::CONFIG_MASK;
		end else if (a == scmgo_pkg::ADDR_ORDER) begin
			mask_of = scmgo_pkg::ORDER_MASK;
		end else if (a < scmgo_pkg::ADDR_RED_OFFSET) begin
			mask_of = scmgo_pkg::GAIN_MASK;
		end else begin
			mask_of = scmgo_pkg::OFFSET_MASK;
		end
	endfunction

	// Reserved bits are forced low so a careless write cannot set them
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++) begin
				mem_reg[i] <= reset_of(i);
			end
		end else if (wr_en) begin
			mem_reg[wr_addr] <= wr_data & mask_of(wr_addr);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_reg <= 9'h000;
		end else begin
			rd_data_reg <= mem_reg[rd_addr];
		end
	end

	assign rd_data = rd_data_reg;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_img
			assign image[g*9 +: 9] = mem_reg[g];
		end
	endgenerate

endmodule // scmgo_regfile

`default_nettype wire

// ==== core/scmgo_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Three-channel with order bit set converts red, green, blue, restarting at red on each data-sample pulse.
// - Three-channel with order bit clear converts blue, green, red, restarting at blue on each data-sample pulse.
// - One-channel mode processes only the colour whose select bit (6 red, 5 green) is set, and blue when neither is set.
// - In one-channel mode the multiplexer stays fixed and ignores converter clock edges.
// - Gain registers keep bits 8..6 at zero and use six bits for 64 settings.
// - Gain code is straight binary, zero giving unity and all ones giving 5.7.
// - Gain equals 5.7 over one plus 4.7 times (63 minus G) over 63.
// - Nine-bit offset registers span minus to plus 350 mV over 512 codes.
// - Offset is sign-magnitude with bit 8 negative, steps near 1.37 mV, both zeros zero.
// - Double-sampling captures reference on reference clock fall and data on data clock fall, outputs the difference.
// - Double-sampling connects the clamp bias while the reference clock is high.
// - Sample-and-hold captures input and offset pin on data clock fall with clamp disabled.
// - Configuration bit 5 selects three-channel when set and one-channel when clear.
// - The converter samples channels on converter clock falls with a three-cycle output latency.
module scmgo_top #(
	parameter int SAMPLE_W  = 14,
	parameter int LATENCY   = 3
) (
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rstn,
	// Register write/read port
	input  wire logic                reg_wr,
	input  wire logic [2:0]          reg_addr,
	input  wire logic [8:0]          reg_wdata,
	output logic      [8:0]          reg_rdata,
	// Sensor timing inputs
	input  wire logic                reference_sample_clock,
	input  wire logic                data_sample_clock,
	input  wire logic                converter_clock,
	// Per-channel converted samples (red, green, blue)
	input  wire logic [SAMPLE_W-1:0] sample_red,
	input  wire logic [SAMPLE_W-1:0] sample_green,
	input  wire logic [SAMPLE_W-1:0] sample_blue,
	// Analog control outputs
	output logic      [1:0]          mux_channel,
	output logic                     clamp_enable,
	output logic                     ref_capture,
	output logic                     data_capture,
	output logic      [5:0]          gain_code,
	output logic      [15:0]         gain_milli,
	output logic      [8:0]          offset_code,
	output logic signed [19:0]       offset_uv,
	// Converted result
	output logic      [SAMPLE_W-1:0] out_data,
	output logic                     out_valid
);

	// ****************************************************************
	// Reset synchroniser
	// ****************************************************************
	logic rst_meta_reg;
	logic rst_n_reg;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [71:0] image;

	scmgo_regfile u_regs (
		.clk_sys (clk_sys),
		.rst_n   (rst_n_reg),
		.wr_en   (reg_wr),
		.wr_addr (reg_addr),
		.wr_data (reg_wdata),
		.rd_addr (reg_addr),
		.rd_data (reg_rdata),
		.image   (image)
	);

	function automatic logic [8:0] reg_at(input logic [71:0] img, input logic [2:0] a);
		reg_at = img[a*9 +: 9];
	endfunction

	wire [8:0] cfg_w   = reg_at(image, scmgo_pkg::ADDR_CONFIG);
	wire [8:0] order_w = reg_at(image, scmgo_pkg::ADDR_ORDER);
	wire three_ch      = cfg_w[scmgo_pkg::CFG_CHANNEL_COUNT_BIT];
	wire double_sample = cfg_w[scmgo_pkg::CFG_DOUBLE_SAMPLE_BIT];
	wire rgb_order     = order_w[scmgo_pkg::ORD_COLOUR_ORDER_BIT];

	// ****************************************************************
	// Edge detection on the timing inputs
	// ****************************************************************
	logic ref_d_reg;
	logic data_d_reg;
	logic conv_d_reg;

	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ref_d_reg  <= 1'b0;
			data_d_reg <= 1'b0;
			conv_d_reg <= 1'b0;
		end else begin
			ref_d_reg  <= reference_sample_clock;
			data_d_reg <= data_sample_clock;
			conv_d_reg <= converter_clock;
		end
	end

	wire ref_fall  = ref_d_reg & ~reference_sample_clock;
	wire data_fall = data_d_reg & ~data_sample_clock;
	wire conv_fall = conv_d_reg & ~converter_clock;

	// Reference capture only exists in double-sampling mode
	assign ref_capture  = double_sample & ref_fall;
	assign data_capture = data_fall;
	// Clamp follows the reference clock level; off in sample-and-hold
	assign clamp_enable = double_sample & reference_sample_clock;

	// ****************************************************************
	// Channel multiplexer
	// ****************************************************************
	// One-hot select picks red first when several bits are set
	wire [1:0] single_ch = order_w[scmgo_pkg::ORD_RED_BIT]   ? 2'(scmgo_pkg::CH_RED)   :
	                       order_w[scmgo_pkg::ORD_GREEN_BIT] ? 2'(scmgo_pkg::CH_GREEN) :
	                                                           2'(scmgo_pkg::CH_BLUE);
	wire [1:0] first_ch = rgb_order ? 2'(scmgo_pkg::CH_RED) : 2'(scmgo_pkg::CH_BLUE);
	wire [1:0] last_ch  = rgb_order ? 2'(scmgo_pkg::CH_BLUE) : 2'(scmgo_pkg::CH_RED);

	function automatic logic [1:0] step_ch(input logic [1:0] c, input logic fwd);
		if (c == 2'(scmgo_pkg::CH_GREEN)) begin
			step_ch = fwd ? 2'(scmgo_pkg::CH_BLUE) : 2'(scmgo_pkg::CH_RED);
		end else begin
			step_ch = 2'(scmgo_pkg::CH_GREEN);
		end
	endfunction

	logic [1:0] chan_reg;
	logic [1:0] chan_next;

	always_comb begin
		chan_next = chan_reg;
		if (!three_ch) begin
			chan_next = single_ch;
		end else if (data_fall) begin
			chan_next = first_ch;
		end else if (conv_fall && chan_reg != last_ch) begin
			chan_next = step_ch(chan_reg, rgb_order);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			chan_reg <= 2'(scmgo_pkg::CH_RED);
		end else begin
			chan_reg <= chan_next;
		end
	end

	assign mux_channel = chan_reg;

	// ****************************************************************
	// Gain and offset of the selected channel
	// ****************************************************************
	wire [2:0] gain_addr = 3'(scmgo_pkg::ADDR_RED_GAIN + {1'b0, chan_reg});
	wire [2:0] ofs_addr  = 3'(scmgo_pkg::ADDR_RED_OFFSET + {1'b0, chan_reg});
	wire [8:0] gain_word = reg_at(image, gain_addr);
	wire [5:0] gsel      = gain_word[5:0];
	wire [8:0] osel      = reg_at(image, ofs_addr);

	// Integer approximation of the curve; exact at both ends
	function automatic logic [15:0] gain_of(input logic [5:0] g);
		int den;
		den = scmgo_pkg::GAIN_UNIT_MILLI * scmgo_pkg::GAIN_MAX_CODE
		    + scmgo_pkg::GAIN_SLOPE_MILL * (scmgo_pkg::GAIN_MAX_CODE - int'(g));
		gain_of = 16'((scmgo_pkg::GAIN_TOP_MILLI * scmgo_pkg::GAIN_MAX_CODE
		              * scmgo_pkg::GAIN_UNIT_MILLI) / den);
	endfunction

	// Sign-magnitude: both zero magnitudes give zero
	function automatic logic signed [19:0] offset_of(input logic [8:0] o);
		int mag;
		mag = (int'(o[7:0]) * scmgo_pkg::OFFSET_SPAN_UV) / scmgo_pkg::OFFSET_MAG_MAX;
		offset_of = 20'(o[scmgo_pkg::OFS_SIGN_BIT] ? -mag : mag);
	endfunction

	logic [5:0]         gain_code_reg;
	logic [15:0]        gain_milli_reg;
	logic [8:0]         offset_code_reg;
	logic signed [19:0] offset_uv_reg;

	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			gain_code_reg   <= 6'h00;
			gain_milli_reg  <= 16'h0000;
			offset_code_reg <= 9'h000;
			offset_uv_reg   <= 20'sh00000;
		end else begin
			gain_code_reg   <= gsel;
			gain_milli_reg  <= gain_of(gsel);
			offset_code_reg <= osel;
			offset_uv_reg   <= offset_of(osel);
		end
	end

	assign gain_code   = gain_code_reg;
	assign gain_milli  = gain_milli_reg;
	assign offset_code = offset_code_reg;
	assign offset_uv   = offset_uv_reg;

	// ****************************************************************
	// Conversion pipeline, counted in converter clock falls
	// ****************************************************************
	wire [SAMPLE_W-1:0] sel_sample = (chan_reg == 2'(scmgo_pkg::CH_RED))   ? sample_red   :
	                                 (chan_reg == 2'(scmgo_pkg::CH_GREEN)) ? sample_green :
	                                                                         sample_blue;

	logic [SAMPLE_W-1:0] pipe_reg [LATENCY];
	logic [LATENCY-1:0]  pvalid_reg;

	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			for (int i = 0; i < LATENCY; i++) begin
				pipe_reg[i] <= '0;
			end
			pvalid_reg <= '0;
		end else if (conv_fall) begin
			pipe_reg[0]   <= sel_sample;
			pvalid_reg[0] <= 1'b1;
			for (int i = 1; i < LATENCY; i++) begin
				pipe_reg[i]   <= pipe_reg[i-1];
				pvalid_reg[i] <= pvalid_reg[i-1];
			end
		end
	end

	logic                out_valid_reg;
	logic [SAMPLE_W-1:0] out_data_reg;

	// The oldest stage leaves on the next fall, so data and valid move together
	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			out_valid_reg <= 1'b0;
			out_data_reg  <= '0;
		end else begin
			out_valid_reg <= conv_fall & pvalid_reg[LATENCY-1];
			if (conv_fall) begin
				out_data_reg <= pipe_reg[LATENCY-1];
			end
		end
	end

	assign out_data  = out_data_reg;
	assign out_valid = out_valid_reg;

endmodule // scmgo_top

`default_nettype wire

// ==== verif/scmgo_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module scmgo_assertions #(
	parameter int SAMPLE_W = 14,
	parameter int LATENCY  = 3
) (
	// Clock, reset, register writes
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic        reg_wr,
	input wire logic [2:0]  reg_addr,
	input wire logic [8:0]  reg_wdata,
	// Timing inputs
	input wire logic        reference_sample_clock,
	input wire logic        data_sample_clock,
	input wire logic        converter_clock,
	// Outputs
	input wire logic [1:0]  mux_channel,
	input wire logic        clamp_enable,
	input wire logic        ref_capture,
	input wire logic        data_capture,
	input wire logic [5:0]  gain_code,
	input wire logic [15:0] gain_milli,
	input wire logic [8:0]  offset_code,
	input wire logic signed [19:0] offset_uv,
	input wire logic        out_valid
);
	// ****************************************************************
	// Shadow of mode registers
	// ****************************************************************
	logic [8:0] cfg_q, ord_q, cfg_next, ord_next;
	logic [3:0] live_q;
	// Checks wait out the internal reset copy and the first output update
	assign cfg_next = (reg_wr && reg_addr == scmgo_pkg::ADDR_CONFIG) ?
		(reg_wdata & scmgo_pkg::CONFIG_MASK) : cfg_q;
	assign ord_next = (reg_wr && reg_addr == scmgo_pkg::ADDR_ORDER) ?
		(reg_wdata & scmgo_pkg::ORDER_MASK) : ord_q;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg_q  <= scmgo_pkg::CONFIG_RESET;
			ord_q  <= scmgo_pkg::ORDER_RESET;
			live_q <= 4'h0;
		end else begin
			cfg_q  <= cfg_next;
			ord_q  <= ord_next;
			live_q <= {live_q[2:0], 1'b1};
		end
	end
	wire logic [1:0] first_ch = ord_q[7] ? 2'h0 : 2'h2;
	wire logic [1:0] last_ch  = ord_q[7] ? 2'h2 : 2'h0;
	wire logic [1:0] next_ch  = ord_q[7] ? mux_channel + 2'h1 : mux_channel - 2'h1;
	wire logic [1:0] sel_ch   = ord_q[6] ? 2'h0 : (ord_q[5] ? 2'h1 : 2'h2);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!live_q[3]);
	sequence s_restart;
		cfg_q[5] && $fell(data_sample_clock);
	endsequence
	sequence s_step;
		cfg_q[5] && $fell(converter_clock) && !$fell(data_sample_clock);
	endsequence
	a_restart_first: assert property (s_restart |=> mux_channel == $past(first_ch))
		else $error("mux did not restart on the first colour");
	a_advance_order: assert property (s_step ##0 mux_channel != last_ch |=>
		mux_channel == $past(next_ch)) else $error("mux skipped the colour order");
	a_hold_last: assert property (s_step ##0 mux_channel == last_ch |=> $stable(mux_channel))
		else $error("mux moved past the last colour");
	a_one_chan_fixed: assert property (!cfg_q[5] |=> mux_channel == $past(sel_ch))
		else $error("single channel mux not on selected colour");
	a_clamp_ref: assert property (clamp_enable == (cfg_q[4] && reference_sample_clock))
		else $error("clamp does not follow reference clock");
	a_ref_capture: assert property (ref_capture == (cfg_q[4] && $fell(reference_sample_clock)))
		else $error("reference capture pulse wrong");
	a_data_capture: assert property (data_capture == $fell(data_sample_clock))
		else $error("data capture pulse wrong");
	a_gain_bottom: assert property (gain_code == 6'h00 |-> gain_milli == 16'h03e8)
		else $error("minimum gain not unity");
	a_gain_top: assert property (gain_code == 6'h3f |-> gain_milli == 16'h1644)
		else $error("maximum gain wrong");
	a_offset_zero: assert property (offset_code[7:0] == 8'h00 |-> offset_uv == 20'sh00000)
		else $error("zero magnitude offset not zero");
	a_offset_full: assert property (offset_code[7:0] == 8'hff |->
		offset_uv == (offset_code[8] ? 20'shaa8d0 : 20'sh55730)) else $error("offset end wrong");
	a_valid_pulse: assert property (out_valid |=> !out_valid)
		else $error("output valid longer than one cycle");
endmodule // scmgo_assertions
bind scmgo_top scmgo_assertions #(.SAMPLE_W(SAMPLE_W), .LATENCY(LATENCY)) chk_u (
	.clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reference_sample_clock(reference_sample_clock),
	.data_sample_clock(data_sample_clock), .converter_clock(converter_clock),
	.mux_channel(mux_channel), .clamp_enable(clamp_enable), .ref_capture(ref_capture),
	.data_capture(data_capture), .gain_code(gain_code), .gain_milli(gain_milli),
	.offset_code(offset_code), .offset_uv(offset_uv), .out_valid(out_valid));
`default_nettype wire

// ==== verif/scmgo_timing_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module scmgo_timing_model (
	// Clock and control
	input  wire logic        clk_sys,
	input  wire logic        run,
	input  wire logic        slow,
	input  wire logic        double_sampling_mode,
	// Sensor timing
	output logic             reference_sample_clock,
	output logic             data_sample_clock,
	output logic             converter_clock,
	// Pixel samples
	output logic      [13:0] sample_red,
	output logic      [13:0] sample_green,
	output logic      [13:0] sample_blue
);
	int   cnt = 0;
	int   unit;
	logic idle = 1'b1;
	// Clocks stand low between frames; stop only where all are low
	assign unit                   = slow ? 2 : 1;
	assign converter_clock        = !idle && cnt < 12 * unit && cnt % (4 * unit) < 2 * unit;
	assign reference_sample_clock = !idle && double_sampling_mode && cnt >= 12 * unit
		&& cnt < 12 * unit + 2;
	assign data_sample_clock      = !idle && cnt >= 12 * unit + 3;
	always @(posedge clk_sys) begin
		if (idle) begin
			if (run) begin
				idle <= 1'b0;
				cnt  <= 12 * unit;
			end
		end else if (cnt == 12 * unit - 1 && !run) begin
			idle <= 1'b1;
		end else if (cnt == 12 * unit + 5) begin
			cnt          <= 0;
			sample_red   <= 14'($urandom);
			sample_green <= 14'($urandom);
			sample_blue  <= 14'($urandom);
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule // scmgo_timing_model
`default_nettype wire

// ==== verif/scmgo_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module scmgo_top_tb;
	typedef struct {logic [1:0] kind; logic [19:0] val;} scmgo_note_t;
	logic clk_sys, rstn, reg_wr, look, run, slow, ds_on, cnv_d = 0, dat_d = 0;
	logic [2:0] reg_addr;
	logic [8:0] reg_wdata, reg_rdata, cfg_sh, ord_sh, d;
	logic reference_sample_clock, data_sample_clock, converter_clock, out_valid;
	logic [13:0] sample_red, sample_green, sample_blue, out_data;
	logic [1:0] mux_channel;
	logic clamp_enable, ref_capture, data_capture;
	logic [5:0] gain_code;
	logic [15:0] gain_milli;
	logic [8:0] offset_code;
	logic signed [19:0] offset_uv;
	int err_total = 0, samples_checked = 0, cyc = 0, idx = 0, ch;
	scmgo_note_t note;
	scmgo_note_t q_rd[$];
	logic [13:0] q_out[$];
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	scmgo_top dut_u (.clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reference_sample_clock(reference_sample_clock), .data_sample_clock(data_sample_clock),
		.converter_clock(converter_clock), .sample_red(sample_red), .sample_green(sample_green),
		.sample_blue(sample_blue), .mux_channel(mux_channel), .clamp_enable(clamp_enable),
		.ref_capture(ref_capture), .data_capture(data_capture), .gain_code(gain_code),
		.gain_milli(gain_milli), .offset_code(offset_code), .offset_uv(offset_uv),
		.out_data(out_data), .out_valid(out_valid));
	scmgo_timing_model tm_u (.clk_sys(clk_sys), .run(run), .slow(slow),
		.double_sampling_mode(ds_on),
		.reference_sample_clock(reference_sample_clock), .data_sample_clock(data_sample_clock),
		.converter_clock(converter_clock), .sample_red(sample_red), .sample_green(sample_green),
		.sample_blue(sample_blue));
	task automatic check(input logic [19:0] act, input logic [19:0] exp);
		samples_checked++;
		if (act !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, act, exp);
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [8:0] v);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		if (a == scmgo_pkg::ADDR_CONFIG) cfg_sh = v & scmgo_pkg::CONFIG_MASK;
		if (a == scmgo_pkg::ADDR_ORDER) ord_sh = v & scmgo_pkg::ORDER_MASK;
	endtask
	// Kind 0 read data, 1 gain in milli, 2 offset in microvolts
	task automatic probe(input logic [1:0] k, input logic [2:0] a, input logic [19:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		q_rd.push_back('{k, e});
		repeat (2) @(posedge clk_sys);
		look <= 1'b1;
		@(posedge clk_sys);
		look <= 1'b0;
	endtask
	task automatic stream(input logic [8:0] c, input logic [8:0] o, input logic s, input int n);
		wr(scmgo_pkg::ADDR_CONFIG, c);
		wr(scmgo_pkg::ADDR_ORDER, o);
		slow <= s;
		ds_on <= c[4];
		run  <= 1'b1;
		repeat (n * (s ? 30 : 18)) @(posedge clk_sys);
		run <= 1'b0;
		repeat (34) @(posedge clk_sys);
	endtask
	// Expected samples follow the partner's own clocks, never the mux output
	always @(posedge clk_sys) begin
		dat_d <= data_sample_clock;
		cnv_d <= converter_clock;
		if (dat_d && !data_sample_clock) idx = 0;
		if (cnv_d && !converter_clock) begin
			ch = !cfg_sh[5] ? (ord_sh[6] ? 0 : (ord_sh[5] ? 1 : 2)) : (ord_sh[7] ? idx : 2 - idx);
			q_out.push_back(ch == 0 ? sample_red : (ch == 1 ? sample_green : sample_blue));
			if (idx < 2) idx++;
		end
	end
	always @(posedge clk_sys) begin
		if (look === 1'b1) begin
			note = q_rd.pop_front();
			check(note.kind == 2'h0 ? 20'(reg_rdata) : (note.kind == 2'h1 ? 20'(gain_milli) :
				offset_uv), note.val);
		end
		if (out_valid === 1'b1)
			check(20'(out_data), q_out.size() > 0 ? 20'(q_out.pop_front()) : 20'hfffff);
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 8000) begin
			err_total++;
			$display("wrong value at %0t: run did not finish", $time);
			end_of_test();
		end
	end
	initial begin
		void'($urandom(68790));
		{rstn, reg_wr, reg_addr, reg_wdata, look, run, slow, ds_on} = '0;
		cfg_sh = scmgo_pkg::CONFIG_RESET;
		ord_sh = scmgo_pkg::ORDER_RESET;
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (int a = 0; a < 8; a++)
			probe(2'h0, 3'(a), 20'(a == 0 ? scmgo_pkg::CONFIG_RESET : (a == 1 ?
				scmgo_pkg::ORDER_RESET : 9'h000)));
		$display("test reset_values done");
		for (int a = 0; a < 8; a++) begin
			d = 9'($urandom);
			wr(3'(a), a == 1 ? d & scmgo_pkg::ORDER_MASK : d);
			probe(2'h0, 3'(a), 20'(d & (a == 0 ? scmgo_pkg::CONFIG_MASK : (a == 1 ?
				scmgo_pkg::ORDER_MASK : (a < 5 ? scmgo_pkg::GAIN_MASK :
				scmgo_pkg::OFFSET_MASK)))));
		end
		$display("test register_masks done");
		stream(9'h078, 9'h0c0, 1'b0, 3);
		stream(9'h078, 9'h040, 1'b1, 3);
		$display("test three_channel done");
		for (int i = 0; i < 4; i++)
			stream(9'h048, (9'h040 >> i) & scmgo_pkg::ORDER_MASK, 1'b0, 2);
		$display("test one_channel done");
		wr(scmgo_pkg::ADDR_ORDER, 9'h020);
		wr(scmgo_pkg::ADDR_GREEN_GAIN, 9'h1ff);
		wr(scmgo_pkg::ADDR_GREEN_OFFSET, 9'h1ff);
		probe(2'h1, 3'h3, 20'h01644);
		probe(2'h2, 3'h6, 20'haa8d0);
		wr(scmgo_pkg::ADDR_GREEN_GAIN, 9'h000);
		wr(scmgo_pkg::ADDR_GREEN_OFFSET, 9'h100);
		probe(2'h1, 3'h3, 20'h003e8);
		probe(2'h2, 3'h6, 20'h00000);
		wr(scmgo_pkg::ADDR_GREEN_OFFSET, 9'h0ff);
		probe(2'h2, 3'h6, 20'h55730);
		$display("test gain_offset done");
		end_of_test();
	end
endmodule // scmgo_top_tb
`default_nettype wire
